// ### logic/tmt_decode.sv
// package of shared types and constants, and the opcode decode table
package tmt_pkg;
  // ----------------------------------------------------------------
  // opcodes handled by this block
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_CTEST_LO = 8'h62; // first complement test
  localparam logic [7:0] OPC_CTEST_HI = 8'h67; // last non-extended complement test
  localparam logic [7:0] OPC_CTEST_EE = 8'h68; // complement test, ext/ext
  localparam logic [7:0] OPC_CTEST_EI = 8'h69; // complement test, ext/imm
  localparam logic [7:0] OPC_TEST_LO = 8'h72; // first plain test
  localparam logic [7:0] OPC_TEST_HI = 8'h77; // last non-extended plain test
  localparam logic [7:0] OPC_TEST_EE = 8'h78; // plain test, ext/ext
  localparam logic [7:0] OPC_TEST_EI = 8'h79; // plain test, ext/imm
  localparam logic [7:0] OPC_TRAP = 8'hf2; // software trap

  // ----------------------------------------------------------------
  // cycle counts
  // ----------------------------------------------------------------
  localparam logic [2:0] FETCH_WREG = 3'h2; // working register dst
  localparam logic [2:0] FETCH_REG = 3'h3; // register or indirect dst
  localparam logic [2:0] FETCH_EXT = 3'h4; // extended address forms
  localparam logic [2:0] EXEC_DIR = 3'h3; // direct src, or immediate src to a direct dst
  localparam logic [2:0] EXEC_IND = 3'h4; // indirect src or indirect dst
  localparam logic [2:0] FETCH_TRAP = 3'h2; // trap fetch
  localparam logic [2:0] EXEC_TRAP = 3'h6; // trap execute

  // ----------------------------------------------------------------
  // flag bit positions and stack steps
  // ----------------------------------------------------------------
  localparam int FLG_C = 7; // carry
  localparam int FLG_Z = 6; // zero
  localparam int FLG_S = 5; // sign
  localparam int FLG_V = 4; // overflow
  localparam int FLG_D = 3; // decimal adjust
  localparam int FLG_H = 2; // half carry
  localparam logic [15:0] SP_PC_DEC = 16'h0002; // room for the pc
  localparam logic [15:0] SP_FLG_DEC = 16'h0001; // room for the flags
  localparam logic [2:0] TRAP_STEP_PC = 3'h0; // push pc
  localparam logic [2:0] TRAP_STEP_FLG = 3'h1; // push flags
  localparam logic [2:0] TRAP_STEP_VEC = 3'h2; // load pc from vector

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AM_NONE, AM_WREG, AM_IWREG, AM_REG, AM_IREG, AM_IMM, AM_EXT, AM_VEC
  } tmt_amode_t;

  typedef enum logic [1:0] {OP_NONE, OP_TEST, OP_CTEST, OP_TRAP} tmt_op_t;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC} tmt_state_t;

  // decoded instruction
  typedef struct packed {
    logic valid;
    tmt_op_t op;
    tmt_amode_t dst;
    tmt_amode_t src;
    logic [2:0] fetch;
    logic [2:0] exec;
  } tmt_dec_t;
endpackage

`timescale 1ns/1ps

// combinational opcode decoder
module tmt_decode
  import tmt_pkg::*;
(
  input wire logic [7:0] opcode,
  output tmt_dec_t dec
);
  // high nibble picks the operation, low nibble the operand pair
  always_comb begin
    dec = '0;
    if (opcode == OPC_TRAP) begin
      dec.valid = 1'b1;
      dec.op = OP_TRAP;
      dec.src = AM_VEC;
      dec.fetch = FETCH_TRAP;
      dec.exec = EXEC_TRAP;
    end else if ((opcode >= OPC_CTEST_LO && opcode <= OPC_CTEST_EI) ||
                 (opcode >= OPC_TEST_LO && opcode <= OPC_TEST_EI)) begin
      dec.valid = 1'b1;
      // 6x is the complement form, 7x the plain form
      dec.op = (opcode[7:4] == OPC_CTEST_LO[7:4]) ? OP_CTEST : OP_TEST;
      dec.exec = EXEC_DIR;
      unique case (opcode[3:0])
        4'h2: begin
          dec.dst = AM_WREG; dec.src = AM_WREG; dec.fetch = FETCH_WREG;
        end
        4'h3: begin
          dec.dst = AM_WREG; dec.src = AM_IWREG; dec.fetch = FETCH_WREG;
          dec.exec = EXEC_IND;
        end
        4'h4: begin
          dec.dst = AM_REG; dec.src = AM_REG; dec.fetch = FETCH_REG;
        end
        4'h5: begin
          dec.dst = AM_REG; dec.src = AM_IREG; dec.fetch = FETCH_REG;
          dec.exec = EXEC_IND;
        end
        4'h6: begin
          dec.dst = AM_REG; dec.src = AM_IMM; dec.fetch = FETCH_REG;
        end
        4'h7: begin
          dec.dst = AM_IREG; dec.src = AM_IMM; dec.fetch = FETCH_REG;
          dec.exec = EXEC_IND;
        end
        4'h8: begin
          dec.dst = AM_EXT; dec.src = AM_EXT; dec.fetch = FETCH_EXT;
        end
        default: begin
          dec.dst = AM_EXT; dec.src = AM_IMM; dec.fetch = FETCH_EXT;
        end
      endcase
    end
  end
endmodule

// ### logic/tmt_core.sv
// test-under-mask and software trap decoder and sequencer
`timescale 1ns/1ps

module tmt_core
  import tmt_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic op_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] dst_val,
  input wire logic [7:0] src_val,
  input wire logic [7:0] flags_in,
  input wire logic [15:0] sp_in,
  input wire logic [15:0] pc_in,
  input wire logic [15:0] vec_data,
  output logic op_ready,
  output tmt_dec_t dec_out,
  output logic busy,
  output logic done,
  output logic illegal,
  output logic flags_we,
  output logic [7:0] flags_out,
  output logic sp_we,
  output logic [15:0] sp_out,
  output logic mem_we,
  output logic mem_wide,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  output logic pc_we,
  output logic [15:0] pc_out
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    tmt_state_t state; // sequencer phase
    logic [2:0] cnt; // cycle within phase
    tmt_dec_t dec; // latched decode
    logic [7:0] dst; // latched destination value
    logic [7:0] src; // latched source value
    logic [7:0] flags; // latched flags
    logic [15:0] sp; // latched stack pointer
    logic [15:0] pc; // latched program counter
    logic done; // end of instruction pulse
    logic illegal; // opcode not handled here
    logic flags_we;
    logic [7:0] flags_out;
    logic sp_we;
    logic [15:0] sp_out;
    logic mem_we;
    logic mem_wide; // 16-bit store
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
    logic pc_we;
    logic [15:0] pc_out;
  } tmt_core_st_t;

  tmt_core_st_t st_q;
  tmt_core_st_t st_d;
  tmt_dec_t dec_now; // decode of the offered opcode
  logic rst_s1_q; // reset release, first stage
  logic rst_s2_q; // reset release, usable copy
  logic accept; // opcode taken this cycle
  logic [7:0] masked; // test result, flags only

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // two-stage release of the asynchronous reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // decode and sequencing
  // ----------------------------------------------------------------
  tmt_decode u_decode (
    .opcode(opcode),
    .dec(dec_now)
  );

  assign op_ready = (st_q.state == ST_IDLE);
  assign accept = op_ready && op_valid && dec_now.valid;

  // masked value; complement form inverts the destination first
  assign masked = ((st_q.dec.op == OP_CTEST) ? ~st_q.dst : st_q.dst) &
                  st_q.src;

  // next state
  always_comb begin
    st_d = st_q;
    // pulses last one cycle
    st_d.done = 1'b0;
    st_d.illegal = 1'b0;
    st_d.flags_we = 1'b0;
    st_d.sp_we = 1'b0;
    st_d.mem_we = 1'b0;
    st_d.pc_we = 1'b0;
    unique case (st_q.state)
      ST_IDLE: begin
        if (accept) begin
          // capture the instruction and its operands
          st_d.state = ST_FETCH;
          st_d.cnt = 3'h0;
          st_d.dec = dec_now;
          st_d.dst = dst_val;
          st_d.src = src_val;
          st_d.flags = flags_in;
          st_d.sp = sp_in;
          st_d.pc = pc_in;
        end else if (op_valid) begin
          // unknown opcode is reported and dropped
          st_d.illegal = 1'b1;
        end
      end
      ST_FETCH: begin
        // hold for the fetch cycle count
        if (st_q.cnt == st_q.dec.fetch - 3'h1) begin
          st_d.state = ST_EXEC;
          st_d.cnt = 3'h0;
        end else begin
          st_d.cnt = st_q.cnt + 3'h1;
        end
      end
      ST_EXEC: begin
        if (st_q.dec.op == OP_TRAP) begin
          // trap: pc word, then flags byte, then vector
          unique case (st_q.cnt)
            TRAP_STEP_PC: begin
              st_d.sp_we = 1'b1;
              st_d.sp_out = st_q.sp - SP_PC_DEC;
              st_d.mem_we = 1'b1;
              st_d.mem_wide = 1'b1;
              st_d.mem_addr = st_q.sp - SP_PC_DEC;
              st_d.mem_wdata = st_q.pc;
            end
            TRAP_STEP_FLG: begin
              st_d.sp_we = 1'b1;
              st_d.sp_out = st_q.sp_out - SP_FLG_DEC;
              st_d.mem_we = 1'b1;
              st_d.mem_wide = 1'b0;
              st_d.mem_addr = st_q.sp_out - SP_FLG_DEC;
              st_d.mem_wdata = {8'h00, st_q.flags};
            end
            TRAP_STEP_VEC: begin
              st_d.pc_we = 1'b1;
              st_d.pc_out = vec_data;
            end
            default: begin
              // remaining cycles are idle time; flags stay put
              st_d.pc_we = 1'b0;
            end
          endcase
        end else if (st_q.cnt == st_q.dec.exec - 3'h1) begin
          // tests update flags only, never the destination
          st_d.flags_we = 1'b1;
          st_d.flags_out = st_q.flags;
          st_d.flags_out[FLG_Z] = (masked == 8'h00);
          st_d.flags_out[FLG_S] = masked[7];
          st_d.flags_out[FLG_V] = 1'b0;
        end
        // finish after the execute cycle count
        if (st_q.cnt == st_q.dec.exec - 3'h1) begin
          st_d.state = ST_IDLE;
          st_d.done = 1'b1;
          st_d.cnt = 3'h0;
        end else begin
          st_d.cnt = st_q.cnt + 3'h1;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign dec_out = st_q.dec;
  assign busy = (st_q.state != ST_IDLE);
  assign done = st_q.done;
  assign illegal = st_q.illegal;
  assign flags_we = st_q.flags_we;
  assign flags_out = st_q.flags_out;
  assign sp_we = st_q.sp_we;
  assign sp_out = st_q.sp_out;
  assign mem_we = st_q.mem_we;
  assign mem_wide = st_q.mem_wide;
  assign mem_addr = st_q.mem_addr;
  assign mem_wdata = st_q.mem_wdata;
  assign pc_we = st_q.pc_we;
  assign pc_out = st_q.pc_out;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // trap stack sequence after acceptance
  sequence s_trap_push;
    ##4 (mem_we && mem_wide && mem_addr == st_q.sp - SP_PC_DEC &&
         mem_wdata == st_q.pc)
    ##1 (mem_we && !mem_wide &&
         mem_addr == st_q.sp - SP_PC_DEC - SP_FLG_DEC &&
         mem_wdata[7:0] == st_q.flags)
    ##1 (pc_we && !mem_we);
  endsequence

  chk_ctest_zero: assert property (@(posedge clk) disable iff (!rst_s2_q)
    flags_we && st_q.dec.op == OP_CTEST |->
      flags_out[FLG_Z] == ((~st_q.dst & st_q.src) == 8'h00))
    else $error("complement test zero flag wrong");
  chk_wreg_timing: assert property (@(posedge clk) disable iff (!rst_s2_q)
    accept && opcode == OPC_CTEST_LO |-> ##1 !done [*5] ##1 done)
    else $error("working register test timing wrong");
  chk_ind_timing: assert property (@(posedge clk) disable iff (!rst_s2_q)
    accept && opcode == OPC_TEST_HI |-> ##8 done)
    else $error("indirect test timing wrong");
  chk_flag_keep: assert property (@(posedge clk) disable iff (!rst_s2_q)
    flags_we |-> (!flags_out[FLG_V] && flags_out[FLG_C] == st_q.flags[FLG_C]
      && flags_out[FLG_D] == st_q.flags[FLG_D]
      && flags_out[FLG_H] == st_q.flags[FLG_H]) ##1 !flags_we)
    else $error("test flag update wrong");
  chk_cext_timing: assert property (@(posedge clk) disable iff (!rst_s2_q)
    accept && opcode == OPC_CTEST_EE |-> ##8 (done && flags_we))
    else $error("extended complement test timing wrong");
  chk_test_sign: assert property (@(posedge clk) disable iff (!rst_s2_q)
    flags_we && st_q.dec.op == OP_TEST |->
      flags_out[FLG_S] == (st_q.dst[7] & st_q.src[7]))
    else $error("plain test sign flag wrong");
  chk_ext_timing: assert property (@(posedge clk) disable iff (!rst_s2_q)
    accept && opcode == OPC_TEST_EI |-> ##8 done)
    else $error("extended test timing wrong");
  chk_trap_stack: assert property (@(posedge clk) disable iff (!rst_s2_q)
    accept && opcode == OPC_TRAP |-> s_trap_push)
    else $error("trap stack sequence wrong");
  chk_trap_len: assert property (@(posedge clk) disable iff (!rst_s2_q)
    accept && opcode == OPC_TRAP |-> ##1 (!flags_we && !done) [*8] ##1 done)
    else $error("trap length or flags wrong");
  chk_no_store: assert property (@(posedge clk) disable iff (!rst_s2_q)
    busy && st_q.dec.op != OP_TRAP |-> !mem_we && !sp_we && !pc_we)
    else $error("test instruction wrote a result");
endmodule

// ### tb/tmt_fetch_model.sv
// fetch unit model: offers opcode bytes and operands to the core
`timescale 1ns/1ps

module tmt_fetch_model (
  input wire logic clk,
  input wire logic op_ready,
  output logic op_valid,
  output logic [7:0] opcode,
  output logic [7:0] dst_val,
  output logic [7:0] src_val,
  output logic [7:0] flags_in,
  output logic [15:0] sp_in,
  output logic [15:0] pc_in,
  output logic [15:0] vec_data
);
  // ---------------------------------------------
  // idle lines at time zero
  // ---------------------------------------------
  initial begin
    op_valid = 1'b0;
    {opcode, dst_val, src_val, flags_in} = 32'h00a55a3c;
    {sp_in, pc_in, vec_data} = 48'h0;
  end

  // ---------------------------------------------
  // offer one opcode, hold it until taken
  // ---------------------------------------------
  task automatic offer(input logic [7:0] opc, dv, sv, fl,
    input logic [15:0] sp, pc, vec, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    op_valid = 1'b1;
    {opcode, dst_val, src_val, flags_in} = {opc, dv, sv, fl};
    {sp_in, pc_in} = {sp, pc};
    vec_data = vec; // vector word kept until the next offer
    while (!ok && n < 40) begin
      @(posedge clk);
      ok = op_ready;
      n++;
    end
    #1;
    // released lines show inverted data so a late sample is caught
    op_valid = 1'b0;
    {opcode, dst_val, src_val, flags_in} = ~{opc, dv, sv, fl};
    {sp_in, pc_in} = ~{sp, pc};
  endtask
endmodule

// ### tb/tmt_core_bench.sv
// self-checking bench for the mask test and trap sequencer
`timescale 1ns/1ps

module tmt_core_bench
  import tmt_pkg::*;
;
  // ---------------------------------------------
  // signals
  // ---------------------------------------------
  logic clk, nrst, op_valid, op_ready, busy, done, illegal;
  logic flags_we, sp_we, mem_we, mem_wide, pc_we;
  logic [7:0] opcode, dst_val, src_val, flags_in, flags_out;
  logic [15:0] sp_in, pc_in, vec_data, sp_out, mem_addr, mem_wdata, pc_out;
  tmt_dec_t dec_out;
  int n_fail = 0;
  int compares = 0;
  time t_done;
  // operand modes by low opcode nibble 2 to 9
  tmt_amode_t dst_tab [2:9] = '{AM_WREG, AM_WREG, AM_REG, AM_REG, AM_REG,
    AM_IREG, AM_EXT, AM_EXT};
  tmt_amode_t src_tab [2:9] = '{AM_WREG, AM_IWREG, AM_REG, AM_IREG, AM_IMM,
    AM_IMM, AM_EXT, AM_IMM};

  initial clk = 1'b0;
  always #10 clk = ~clk;

  tmt_fetch_model u_tmt_fetch_model (.clk(clk), .op_ready(op_ready),
    .op_valid(op_valid), .opcode(opcode), .dst_val(dst_val),
    .src_val(src_val), .flags_in(flags_in), .sp_in(sp_in), .pc_in(pc_in),
    .vec_data(vec_data));

  tmt_core u_tmt_core (.clk(clk), .nrst(nrst), .op_valid(op_valid),
    .opcode(opcode), .dst_val(dst_val), .src_val(src_val),
    .flags_in(flags_in), .sp_in(sp_in), .pc_in(pc_in), .vec_data(vec_data),
    .op_ready(op_ready), .dec_out(dec_out), .busy(busy), .done(done),
    .illegal(illegal), .flags_we(flags_we), .flags_out(flags_out),
    .sp_we(sp_we), .sp_out(sp_out), .mem_we(mem_we), .mem_wide(mem_wide),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .pc_we(pc_we),
    .pc_out(pc_out));

  // ---------------------------------------------
  // compare and verdict
  // ---------------------------------------------
  task automatic check(input logic [63:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------
  // follow one accepted opcode to done
  // ---------------------------------------------
  task automatic track(input logic [7:0] opc, dv, sv, fl,
    input logic [15:0] sp, pc, vec);
    logic [7:0] res, ef;
    logic [3:0] lo;
    logic [2:0] nf, ne;
    logic [8:0] dx;
    logic [15:0] s2, s3;
    logic trap;
    tmt_op_t eop;
    int k, nst, nfw;
    lo = opc[3:0];
    trap = (opc == 8'hf2);
    s2 = sp - 16'h0002;
    s3 = sp - 16'h0003;
    res = (opc[4] ? dv : ~dv) & sv;
    ef = (fl & 8'h8f) | {1'b0, res == 8'h00, res[7], 5'h00};
    nf = trap ? 3'h2 : (lo > 4'h7 ? 3'h4 : (lo < 4'h4 ? 3'h2 : 3'h3));
    ne = trap ? 3'h6 : ((lo < 4'h8 && lo[0]) ? 3'h4 : 3'h3);
    eop = trap ? OP_TRAP : (opc[4] ? OP_TEST : OP_CTEST);
    k = 0;
    nst = 0;
    nfw = 0;
    while (k < 12 && done !== 1'b1) begin
      @(posedge clk);
      #1;
      k++;
      nst += ((mem_we | sp_we | pc_we) === 1'b1);
      nfw += (flags_we === 1'b1);
      if (trap && k == 3) begin
        check({mem_we, mem_wide, mem_addr}, {2'b11, s2});
        check({mem_wdata, sp_we, sp_out}, {pc, 1'b1, s2});
      end
      if (trap && k == 4) begin
        check({mem_we, mem_wide, mem_addr}, {2'b10, s3});
        check({mem_wdata[7:0], sp_we, sp_out}, {fl, 1'b1, s3});
      end
      if (trap && k == 5) begin
        check({pc_we, pc_out}, {1'b1, vec});
      end
    end
    t_done = $time;
    check(k, int'(nf) + int'(ne));
    dx = {dec_out.valid, dec_out.op, dec_out.fetch, dec_out.exec};
    check(dx, {1'b1, eop, nf, ne});
    if (trap) begin
      check({nfw, nst}, {32'd0, 32'd3});
    end else begin
      check({dec_out.dst, dec_out.src}, {dst_tab[lo], src_tab[lo]});
      check({flags_we, flags_out[7:2]}, {1'b1, ef[7:2]});
      check({nfw, nst}, {32'd1, 32'd0});
    end
  endtask

  task automatic run(input logic [7:0] opc, dv, sv, fl);
    logic ok;
    u_tmt_fetch_model.offer(opc, dv, sv, fl, {dv, sv}, {sv, fl}, {fl, dv},
      ok);
    check(ok, 1);
    track(opc, dv, sv, fl, {dv, sv}, {sv, fl}, {fl, dv});
  endtask

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  // every test opcode, operands giving sign, zero and carry kept
  task automatic sc_tests();
    logic [23:0] set [3] = '{24'h0ff0ff, 24'h35c600, 24'hff80a5};
    logic [7:0] d, s, f;
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 3; j++) begin
        {d, s, f} = set[j];
        run(8'h62 + 8'(i), d, s, f);
        run(8'h72 + 8'(i), d, s, f);
      end
    end
  endtask

  // trap with all flags set and with a stack wrap
  task automatic sc_trap();
    run(8'hf2, 8'h5a, 8'h3c, 8'hff);
    run(8'hf2, 8'h00, 8'h01, 8'h00);
  endtask

  // a test offered while a trap runs is taken in the done cycle
  task automatic sc_busy();
    logic ok;
    fork
      run(8'hf2, 8'h12, 8'h34, 8'h56);
      begin
        repeat (3) @(posedge clk);
        #1;
        u_tmt_fetch_model.offer(8'h77, 8'h81, 8'h81, 8'h00, 16'h0, 16'h0,
          16'h5612, ok);
      end
    join
    check(ok, 1);
    check($time - t_done, 20);
    track(8'h77, 8'h81, 8'h81, 8'h00, 16'h0, 16'h0, 16'h5612);
  endtask

  // opcodes just outside the handled ranges, and 00, are refused
  task automatic sc_illegal();
    logic [7:0] bad [7] = '{8'h61, 8'h6a, 8'h71, 8'h7a, 8'hf1, 8'hf3, 8'h00};
    logic ok;
    foreach (bad[i]) begin
      u_tmt_fetch_model.offer(bad[i], 8'h0, 8'h0, 8'h0, 16'h0, 16'h0,
        16'h0, ok);
      // the refusal pulse stands in the cycle after the offer edge
      check({ok, illegal, busy, done}, 4'b1100);
      @(posedge clk);
      #1;
      check(illegal, 0);
    end
  endtask

  // ---------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------
  initial begin
    nrst = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    check({busy, done, illegal, flags_we, sp_we, mem_we, pc_we}, 0);
    check(op_ready, 1);
    nrst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    sc_tests();
    sc_trap();
    sc_busy();
    sc_illegal();
    summarize();
  end

  initial begin
    #400000;
    n_fail++;
    summarize();
  end
endmodule
